//--- hw/dual_counter_pkg.sv
package dual_counter_pkg;
  localparam logic [3:0] BANK_COUNTERS = 4'hD;
  localparam logic [3:0] OFS_NARROW_CTRL = 4'h0;
  localparam logic [3:0] OFS_SHARED_CTRL = 4'h1;
  localparam logic [3:0] OFS_WIDE_CTRL = 4'h2;
  localparam logic [3:0] OFS_NARROW_RL_LO = 4'h6;
  localparam logic [3:0] OFS_NARROW_RL_HI = 4'h7;
  localparam logic [3:0] OFS_CAPTURE_LO = 4'h8;
  localparam logic [3:0] OFS_CAPTURE_HI = 4'h9;
  localparam logic [3:0] OFS_WIDE_RL_LO = 4'hA;
  localparam logic [3:0] OFS_WIDE_RL_HI = 4'hB;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ONCE = 6;
  localparam int BIT_STATUS = 5;
  localparam int BIT_CAP_STATUS = 4;
  localparam int BIT_CAP_IE = 2;
  localparam int BIT_TC_IE = 1;
  localparam int BIT_MODE = 7;
  localparam int FLD_LOGIC_LO = 4;
  localparam int FLD_SUB_LO = 2;
  localparam int BIT_INIT_NARROW = 1;
  localparam int BIT_INIT_WIDE = 0;
  localparam logic [1:0] LOGIC_AND = 2'h0;
  localparam logic [1:0] LOGIC_OR = 2'h1;
  localparam logic [1:0] LOGIC_NOR = 2'h2;
  localparam logic [1:0] LOGIC_NAND = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PINGPONG = 2'h1;
  localparam logic [1:0] SUB_FORCE0 = 2'h2;
  localparam logic [1:0] SUB_FORCE1 = 2'h3;
  localparam logic [3:0] GLITCH_W0 = 4'h0;
  localparam logic [3:0] GLITCH_W1 = 4'h2;
  localparam logic [3:0] GLITCH_W2 = 4'h4;
  localparam logic [3:0] GLITCH_W3 = 4'h8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [15:0] WIDE_RST = 16'h0000;
  localparam logic [7:0] TICK_DIV_DEF = 8'h04;

  typedef struct packed {
    logic [3:0] bank;
    logic [3:0] addr;
    logic wr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic narrow;
    logic wide;
    logic combined;
  } pin_out_t;
endpackage

//--- hw/dual_counter_transmit_demod.sv
`timescale 1ns/1ps
module dual_counter_transmit_demod #(
  parameter logic [7:0] TICK_DIV = dual_counter_pkg::TICK_DIV_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register access
  input wire dual_counter_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Pins
  input wire logic demod_in,
  output dual_counter_pkg::pin_out_t pin_out,
  // Event levels
  output logic narrow_irq,
  output logic wide_irq
);
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] n_rl_hi;
    logic [7:0] n_rl_lo;
    logic [7:0] w_rl_hi;
    logic [7:0] w_rl_lo;
    logic [15:0] cap;
    logic [7:0] n_cnt;
    logic [15:0] w_cnt;
    logic n_en_d;
    logic w_en_d;
    logic n_run;
    logic w_run;
    logic n_out;
    logic w_out;
    logic comb_out;
    logic rise_flag;
    logic fall_flag;
    logic armed;
    logic pin_s1;
    logic pin_s2;
    logic filt;
    logic filt_d;
    logic [3:0] glitch_cnt;
    logic [7:0] div_cnt;
    logic tick;
    logic [7:0] rdata;
    logic irq_n;
    logic irq_w;
  } state_t;

  localparam logic [15:0] WIDE_ZERO = dual_counter_pkg::WIDE_RST;
  state_t q_ff;
  state_t nxt_q;

  always_comb begin
    logic hit;
    logic demod;
    logic pp;
    logic [1:0] logic_fld;
    logic [1:0] sub_fld;
    logic [3:0] glitch_w;
    logic rise;
    logic fall;
    logic edge_hit;
    logic n_start;
    logic w_start;
    logic n_tc;
    logic w_tc;
    logic n_new;
    logic w_new;
    hit = 1'b0;
    demod = 1'b0;
    pp = 1'b0;
    logic_fld = 2'h0;
    sub_fld = 2'h0;
    glitch_w = 4'h0;
    rise = 1'b0;
    fall = 1'b0;
    edge_hit = 1'b0;
    n_start = 1'b0;
    w_start = 1'b0;
    n_tc = 1'b0;
    w_tc = 1'b0;
    n_new = 1'b0;
    w_new = 1'b0;
    nxt_q = q_ff;

    demod = q_ff.ctrl1[dual_counter_pkg::BIT_MODE];
    logic_fld = q_ff.ctrl1[dual_counter_pkg::FLD_LOGIC_LO +: 2];
    sub_fld = q_ff.ctrl1[dual_counter_pkg::FLD_SUB_LO +: 2];
    // Hand-over between counters only while ping-pong is selected
    pp = !demod && (sub_fld == dual_counter_pkg::SUB_PINGPONG);

    // Counting rate
    if (q_ff.div_cnt >= TICK_DIV - 8'h01) begin
      nxt_q.div_cnt = 8'h00;
      nxt_q.tick = 1'b1;
    end else begin
      nxt_q.div_cnt = q_ff.div_cnt + 8'h01;
      nxt_q.tick = 1'b0;
    end

    // Pin synchroniser and glitch filter
    nxt_q.pin_s1 = demod_in;
    nxt_q.pin_s2 = q_ff.pin_s1;
    case (sub_fld)
      2'h0: glitch_w = dual_counter_pkg::GLITCH_W0;
      2'h1: glitch_w = dual_counter_pkg::GLITCH_W1;
      2'h2: glitch_w = dual_counter_pkg::GLITCH_W2;
      default: glitch_w = dual_counter_pkg::GLITCH_W3;
    endcase
    if (q_ff.pin_s2 == q_ff.filt) begin
      nxt_q.glitch_cnt = 4'h0;
    end else if (q_ff.glitch_cnt >= glitch_w) begin
      nxt_q.filt = q_ff.pin_s2;
      nxt_q.glitch_cnt = 4'h0;
    end else begin
      nxt_q.glitch_cnt = q_ff.glitch_cnt + 4'h1;
    end
    nxt_q.filt_d = q_ff.filt;
    rise = q_ff.filt && !q_ff.filt_d;
    fall = !q_ff.filt && q_ff.filt_d;
    // Only the selected polarity reaches the flags and the capture
    rise = rise && (logic_fld != dual_counter_pkg::EDGE_FALL);
    fall = fall && (logic_fld != dual_counter_pkg::EDGE_RISE);
    edge_hit = rise || fall;

    // Register writes, bank selected by the register pointer
    hit = reg_req.wr && (reg_req.bank == dual_counter_pkg::BANK_COUNTERS);
    if (hit) begin
      case (reg_req.addr)
        dual_counter_pkg::OFS_NARROW_CTRL: begin
          nxt_q.ctrl0 = reg_req.wdata;
          nxt_q.ctrl0[dual_counter_pkg::BIT_STATUS] = q_ff.ctrl0[dual_counter_pkg::BIT_STATUS] &&
            !reg_req.wdata[dual_counter_pkg::BIT_STATUS];
        end
        dual_counter_pkg::OFS_SHARED_CTRL: begin
          if (reg_req.wdata[dual_counter_pkg::BIT_MODE]) begin
            nxt_q.ctrl1[7:2] = reg_req.wdata[7:2];
            if (reg_req.wdata[dual_counter_pkg::BIT_INIT_NARROW]) begin
              nxt_q.rise_flag = 1'b0;
            end
            if (reg_req.wdata[dual_counter_pkg::BIT_INIT_WIDE]) begin
              nxt_q.fall_flag = 1'b0;
            end
          end else begin
            nxt_q.ctrl1 = reg_req.wdata;
          end
        end
        dual_counter_pkg::OFS_WIDE_CTRL: begin
          nxt_q.ctrl2 = reg_req.wdata;
          nxt_q.ctrl2[dual_counter_pkg::BIT_STATUS] = q_ff.ctrl2[dual_counter_pkg::BIT_STATUS] &&
            !reg_req.wdata[dual_counter_pkg::BIT_STATUS];
          nxt_q.ctrl2[dual_counter_pkg::BIT_CAP_STATUS] = q_ff.ctrl2[dual_counter_pkg::BIT_CAP_STATUS] &&
            !reg_req.wdata[dual_counter_pkg::BIT_CAP_STATUS];
          if (reg_req.wdata[dual_counter_pkg::BIT_ONCE] && !q_ff.ctrl2[dual_counter_pkg::BIT_ONCE]) begin
            nxt_q.armed = 1'b1;
          end
        end
        dual_counter_pkg::OFS_NARROW_RL_LO: nxt_q.n_rl_lo = reg_req.wdata;
        dual_counter_pkg::OFS_NARROW_RL_HI: nxt_q.n_rl_hi = reg_req.wdata;
        dual_counter_pkg::OFS_WIDE_RL_LO: nxt_q.w_rl_lo = reg_req.wdata;
        dual_counter_pkg::OFS_WIDE_RL_HI: nxt_q.w_rl_hi = reg_req.wdata;
        default: ;
      endcase
    end

    // Edge flags, set wins over a clear in the same cycle
    if (demod && rise) begin
      nxt_q.rise_flag = 1'b1;
    end
    if (demod && fall) begin
      nxt_q.fall_flag = 1'b1;
    end

    // Narrow counter
    nxt_q.n_en_d = q_ff.ctrl0[dual_counter_pkg::BIT_ENABLE];
    n_start = q_ff.ctrl0[dual_counter_pkg::BIT_ENABLE] && !q_ff.n_en_d;
    if (!q_ff.ctrl0[dual_counter_pkg::BIT_ENABLE]) begin
      nxt_q.n_run = 1'b0;
      nxt_q.n_out = !q_ff.ctrl1[dual_counter_pkg::BIT_INIT_NARROW];
    end else if (n_start) begin
      nxt_q.n_run = 1'b1;
      nxt_q.n_out = q_ff.ctrl1[dual_counter_pkg::BIT_INIT_NARROW];
      nxt_q.n_cnt = q_ff.ctrl1[dual_counter_pkg::BIT_INIT_NARROW] ? q_ff.n_rl_hi : q_ff.n_rl_lo;
    end else if (q_ff.n_run && q_ff.tick) begin
      if (q_ff.n_cnt <= 8'h01) begin
        n_tc = 1'b1;
        n_new = !q_ff.n_out;
        nxt_q.n_out = n_new;
        nxt_q.n_cnt = n_new ? q_ff.n_rl_hi : q_ff.n_rl_lo;
        nxt_q.ctrl0[dual_counter_pkg::BIT_STATUS] = 1'b1;
        if (pp) begin
          nxt_q.n_run = 1'b0;
          nxt_q.ctrl0[dual_counter_pkg::BIT_ENABLE] = 1'b0;
          nxt_q.ctrl2[dual_counter_pkg::BIT_ENABLE] = 1'b1;
        end else if (q_ff.ctrl0[dual_counter_pkg::BIT_ONCE]) begin
          nxt_q.n_run = 1'b0;
        end
      end else begin
        nxt_q.n_cnt = q_ff.n_cnt - 8'h01;
      end
    end

    // Wide counter
    nxt_q.w_en_d = q_ff.ctrl2[dual_counter_pkg::BIT_ENABLE];
    w_start = q_ff.ctrl2[dual_counter_pkg::BIT_ENABLE] && !q_ff.w_en_d;
    if (!q_ff.ctrl2[dual_counter_pkg::BIT_ENABLE]) begin
      nxt_q.w_run = 1'b0;
      nxt_q.w_out = !q_ff.ctrl1[dual_counter_pkg::BIT_INIT_WIDE];
    end else if (w_start) begin
      nxt_q.w_run = 1'b1;
      nxt_q.w_out = q_ff.ctrl1[dual_counter_pkg::BIT_INIT_WIDE];
      nxt_q.w_cnt = {q_ff.w_rl_hi, q_ff.w_rl_lo};
    end else if (demod) begin
      if (q_ff.ctrl2[dual_counter_pkg::BIT_ONCE] ? (edge_hit && q_ff.armed) : edge_hit) begin
        nxt_q.cap = q_ff.w_cnt;
        nxt_q.w_cnt = {q_ff.w_rl_hi, q_ff.w_rl_lo};
        nxt_q.armed = 1'b0;
        nxt_q.ctrl2[dual_counter_pkg::BIT_CAP_STATUS] = 1'b1;
      end else if (q_ff.tick) begin
        nxt_q.w_cnt = q_ff.w_cnt - 16'h0001;
        if (q_ff.w_cnt == WIDE_ZERO) begin
          nxt_q.ctrl2[dual_counter_pkg::BIT_STATUS] = 1'b1;
        end
      end
      if (n_tc && q_ff.ctrl2[dual_counter_pkg::BIT_ONCE]) begin
        nxt_q.cap = q_ff.w_cnt;
        nxt_q.ctrl2[dual_counter_pkg::BIT_CAP_STATUS] = 1'b1;
      end
    end else if (q_ff.w_run && q_ff.tick) begin
      if (q_ff.w_cnt <= 16'h0001) begin
        w_tc = 1'b1;
        w_new = !q_ff.w_out;
        nxt_q.w_out = w_new;
        nxt_q.ctrl2[dual_counter_pkg::BIT_STATUS] = 1'b1;
        nxt_q.w_cnt = {q_ff.w_rl_hi, q_ff.w_rl_lo};
        if (pp) begin
          nxt_q.w_run = 1'b0;
          nxt_q.ctrl2[dual_counter_pkg::BIT_ENABLE] = 1'b0;
          nxt_q.ctrl0[dual_counter_pkg::BIT_ENABLE] = 1'b1;
        end else if (q_ff.ctrl2[dual_counter_pkg::BIT_ONCE]) begin
          nxt_q.w_run = 1'b0;
        end
      end else begin
        nxt_q.w_cnt = q_ff.w_cnt - 16'h0001;
      end
    end

    // Forced wide output overrides counting, enabled or not
    if (!demod && (sub_fld == dual_counter_pkg::SUB_FORCE0)) begin
      nxt_q.w_out = 1'b0;
    end else if (!demod && (sub_fld == dual_counter_pkg::SUB_FORCE1)) begin
      nxt_q.w_out = 1'b1;
    end

    case (logic_fld)
      dual_counter_pkg::LOGIC_AND: nxt_q.comb_out = nxt_q.n_out && nxt_q.w_out;
      dual_counter_pkg::LOGIC_OR: nxt_q.comb_out = nxt_q.n_out || nxt_q.w_out;
      dual_counter_pkg::LOGIC_NOR: nxt_q.comb_out = !(nxt_q.n_out || nxt_q.w_out);
      default: nxt_q.comb_out = !(nxt_q.n_out && nxt_q.w_out);
    endcase

    nxt_q.irq_n = nxt_q.ctrl0[dual_counter_pkg::BIT_STATUS] && nxt_q.ctrl0[dual_counter_pkg::BIT_TC_IE];
    nxt_q.irq_w = (nxt_q.ctrl2[dual_counter_pkg::BIT_STATUS] && nxt_q.ctrl2[dual_counter_pkg::BIT_TC_IE]) ||
      (nxt_q.ctrl2[dual_counter_pkg::BIT_CAP_STATUS] && nxt_q.ctrl2[dual_counter_pkg::BIT_CAP_IE]);

    // Read data, one cycle behind the address
    nxt_q.rdata = 8'h00;
    if (reg_req.bank == dual_counter_pkg::BANK_COUNTERS) begin
      case (reg_req.addr)
        dual_counter_pkg::OFS_NARROW_CTRL: nxt_q.rdata = q_ff.ctrl0;
        dual_counter_pkg::OFS_SHARED_CTRL: nxt_q.rdata = demod ?
          {q_ff.ctrl1[7:2], q_ff.rise_flag, q_ff.fall_flag} : q_ff.ctrl1;
        dual_counter_pkg::OFS_WIDE_CTRL: nxt_q.rdata = q_ff.ctrl2;
        dual_counter_pkg::OFS_NARROW_RL_LO: nxt_q.rdata = q_ff.n_rl_lo;
        dual_counter_pkg::OFS_NARROW_RL_HI: nxt_q.rdata = q_ff.n_rl_hi;
        dual_counter_pkg::OFS_CAPTURE_LO: nxt_q.rdata = q_ff.cap[7:0];
        dual_counter_pkg::OFS_CAPTURE_HI: nxt_q.rdata = q_ff.cap[15:8];
        dual_counter_pkg::OFS_WIDE_RL_LO: nxt_q.rdata = q_ff.w_rl_lo;
        dual_counter_pkg::OFS_WIDE_RL_HI: nxt_q.rdata = q_ff.w_rl_hi;
        default: nxt_q.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_ff <= '0;
      q_ff.n_out <= 1'b1;
      q_ff.w_out <= 1'b1;
      q_ff.comb_out <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign reg_rdata = q_ff.rdata;
  assign pin_out.narrow = q_ff.n_out;
  assign pin_out.wide = q_ff.w_out;
  assign pin_out.combined = q_ff.comb_out;
  assign narrow_irq = q_ff.irq_n;
  assign wide_irq = q_ff.irq_w;
endmodule // dual_counter_transmit_demod

//--- hw/_unused_placeholder_none.sv
`timescale 1ns/1ps

//--- tb/dual_counter_chk.sv
`timescale 1ns/1ps
module dual_counter_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register access
  input wire dual_counter_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // Pins and events
  input wire logic demod_in,
  input wire dual_counter_pkg::pin_out_t pin_out,
  input wire logic narrow_irq,
  input wire logic wide_irq
);
  // Software copy of the control registers; calm counts cycles since a write
  logic [7:0] c0_ff, sh_ff, c2_ff;
  logic [2:0] calm_ff;
  logic wr_d;
  assign wr_d = reg_req.wr && reg_req.bank == dual_counter_pkg::BANK_COUNTERS;
  function automatic logic mix(input logic [1:0] f, input logic a, input logic b);
    return f == 2'h0 ? a & b : f == 2'h1 ? a | b : f == 2'h2 ? !(a | b) : !(a & b);
  endfunction
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {c0_ff, sh_ff, c2_ff, calm_ff} <= '0;
    end else begin
      calm_ff <= wr_d ? 3'h0 : calm_ff + {2'h0, calm_ff != 3'h7};
      if (wr_d && reg_req.addr == 4'h0) c0_ff <= reg_req.wdata;
      if (wr_d && reg_req.addr == 4'h2) c2_ff <= reg_req.wdata;
      // Low bits are flag clears in demodulation
      if (wr_d && reg_req.addr == 4'h1) sh_ff <= {reg_req.wdata[7:2],
        reg_req.wdata[7] ? sh_ff[1:0] : reg_req.wdata[1:0]};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_combine;
    !$past(sh_ff[7]) |-> pin_out.combined == mix($past(sh_ff[5:4]), pin_out.narrow, pin_out.wide);
  endproperty
  a_combine: assert property (p_combine) else $error("combined output wrong");
  property p_unmapped;
    (reg_req.bank != 4'hD || reg_req.addr inside {[4'h3:4'h5], [4'hC:4'hF]}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_force0;
    !$past(sh_ff[7]) && $past(sh_ff[3:2]) == 2'h2 |-> !pin_out.wide;
  endproperty
  a_force0: assert property (p_force0) else $error("wide output not forced low");
  property p_force1;
    !$past(sh_ff[7]) && $past(sh_ff[3:2]) == 2'h3 |-> pin_out.wide;
  endproperty
  a_force1: assert property (p_force1) else $error("wide output not forced high");
  property p_narrow_idle;
    calm_ff > 3'h3 && !sh_ff[7] && sh_ff[3:2] == 2'h0 && !c0_ff[7] |-> pin_out.narrow == !sh_ff[1];
  endproperty
  a_narrow_idle: assert property (p_narrow_idle) else $error("idle narrow level wrong");
  property p_wide_idle;
    calm_ff > 3'h3 && !sh_ff[7] && sh_ff[3:2] == 2'h0 && !c2_ff[7] |-> pin_out.wide == !sh_ff[0];
  endproperty
  a_wide_idle: assert property (p_wide_idle) else $error("idle wide level wrong");
  property p_narrow_irq;
    calm_ff > 3'h1 && !c0_ff[1] |-> !narrow_irq;
  endproperty
  a_narrow_irq: assert property (p_narrow_irq) else $error("masked narrow event raised");
  property p_wide_irq;
    calm_ff > 3'h1 && c2_ff[2:1] == 2'h0 |-> !wide_irq;
  endproperty
  a_wide_irq: assert property (p_wide_irq) else $error("masked wide event raised");
endmodule // dual_counter_chk
bind dual_counter_transmit_demod dual_counter_chk i_chk (.clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .demod_in(demod_in), .pin_out(pin_out), .narrow_irq(narrow_irq), .wide_irq(wide_irq));

//--- tb/pin_source.sv
`timescale 1ns/1ps
module pin_source (
  // Clock and pulse request
  input wire logic clk_sys,
  input wire logic fire,
  input wire logic [7:0] hold_len,
  // Pin toward the block
  output logic demod_in
);
  // Cycles left high; the line rests low between pulses
  logic [7:0] left_ff = 8'h00;
  always_ff @(posedge clk_sys) begin
    if (fire) left_ff <= hold_len;
    else if (left_ff != 8'h00) left_ff <= left_ff - 8'h01;
  end
  assign demod_in = left_ff != 8'h00;
endmodule // pin_source

//--- tb/tb_dual_counter_transmit_demod.sv
`timescale 1ns/1ps
module tb_dual_counter_transmit_demod;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic fire = 1'b0;
  logic [7:0] hold_len = 8'h00;
  logic demod_in, narrow_irq, wide_irq;
  logic [7:0] reg_rdata, d;
  int n;
  int err_total = 0;
  int compares = 0;
  dual_counter_pkg::reg_req_t reg_req = '0;
  dual_counter_pkg::pin_out_t pin_out;
  always #12.5 clk_sys = ~clk_sys;
  dual_counter_transmit_demod #(.TICK_DIV(8'h01)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .demod_in(demod_in), .pin_out(pin_out), .narrow_irq(narrow_irq), .wide_irq(wide_irq));
  pin_source i_src (.clk_sys(clk_sys), .fire(fire), .hold_len(hold_len), .demod_in(demod_in));
  function automatic logic mix(input logic [1:0] f, input logic a, input logic b);
    return f == 2'h0 ? a & b : f == 2'h1 ? a | b : f == 2'h2 ? !(a | b) : !(a & b);
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    cyc(1);
    reg_req = '{4'hD, a, 1'b1, v};
    cyc(1);
    reg_req.wr = 1'b0;
  endtask
  task rd(input logic [3:0] b, input logic [3:0] a);
    cyc(1);
    reg_req = '{b, a, 1'b0, 8'h00};
    cyc(1);
    d = reg_rdata;
  endtask
  // Counts cycles until the chosen output changes, giving up at 600
  task tog(input bit w);
    logic v;
    v = w ? pin_out.wide : pin_out.narrow;
    n = 0;
    while ((w ? pin_out.wide : pin_out.narrow) === v && n < 600) begin
      cyc(1);
      n++;
    end
  endtask
  task pulse(input logic [7:0] len);
    hold_len = len;
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    cyc(30);
  endtask
  task t_logic;
    rd(4'hD, 4'h2);
    check(d, 8'h00);
    rd(4'h0, 4'h2);
    check(d, 8'h00);
    for (int f = 0; f < 4; f++)
      for (int i = 0; i < 4; i++) begin
        wr(4'h1, {2'h0, f[1:0], 2'h0, i[1:0]});
        cyc(4);
        check(pin_out, {!i[1], !i[0], mix(f[1:0], !i[1], !i[0])});
      end
    $display("logic test done");
  endtask
  task t_force;
    wr(4'hA, 8'h05);
    wr(4'h2, 8'h80);
    for (int s = 2; s < 4; s++) begin
      wr(4'h1, {4'h0, s[1:0], 2'h3});
      cyc(2);
      check(pin_out.wide, s[0]);
      cyc(11);
      check(pin_out.wide, s[0]);
    end
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h00);
    cyc(4);
    check(pin_out.wide, 1'b1);
    $display("force test done");
  endtask
  task t_wide;
    wr(4'hA, 8'h03);
    wr(4'h2, 8'h80);
    tog(1);
    check(pin_out.wide, 1'b0);
    tog(1);
    tog(1);
    check(n, 3);
    wr(4'hA, 8'h05);
    tog(1);
    check(n, 1);
    tog(1);
    check(n, 5);
    rd(4'hD, 4'h2);
    check(d, 8'hA0);
    wr(4'h2, 8'h00);
    wr(4'h2, 8'h20);
    rd(4'hD, 4'h2);
    check(d, 8'h00);
    wr(4'hB, 8'h01);
    wr(4'hA, 8'h00);
    wr(4'h2, 8'h80);
    repeat (3) tog(1);
    check(n, 256);
    wr(4'h2, 8'h00);
    wr(4'hB, 8'h00);
    wr(4'hA, 8'h03);
    wr(4'h2, 8'hC0);
    repeat (3) tog(1);
    check(n, 600);
    wr(4'h2, 8'h20);
    $display("wide counter test done");
  endtask
  task t_narrow;
    wr(4'h1, 8'h02);
    cyc(4);
    check(pin_out.narrow, 1'b0);
    wr(4'h6, 8'h04);
    wr(4'h0, 8'h82);
    tog(0);
    check(pin_out.narrow, 1'b1);
    cyc(2);
    check(narrow_irq, 1'b1);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    $display("narrow start test done");
  endtask
  task t_demod;
    wr(4'h1, 8'hA0);
    pulse(8'h05);
    rd(4'hD, 4'h1);
    check(d, 8'hA3);
    wr(4'h1, 8'hAF);
    rd(4'hD, 4'h1);
    check(d, 8'hAC);
    pulse(8'h03);
    rd(4'hD, 4'h1);
    check(d, 8'hAC);
    pulse(8'h0C);
    rd(4'hD, 4'h1);
    check(d, 8'hAF);
    wr(4'h1, 8'h83);
    pulse(8'h05);
    rd(4'hD, 4'h1);
    check(d, 8'h82);
    wr(4'h1, 8'h83);
    wr(4'h1, 8'h00);
    $display("demodulation test done");
  endtask
  task t_pingpong;
    wr(4'h0, 8'h60);
    wr(4'h2, 8'h70);
    wr(4'h6, 8'h08);
    wr(4'h7, 8'h08);
    wr(4'hA, 8'h04);
    wr(4'h1, 8'h04);
    wr(4'h0, 8'hC0);
    tog(1);
    check(n < 600, 1'b1);
    tog(1);
    tog(0);
    check(n < 600, 1'b1);
    wr(4'h1, 8'h00);
    tog(1);
    check(n, 600);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h00);
    $display("ping-pong test done");
  endtask
  task t_capture;
    wr(4'h1, 8'h80);
    wr(4'hA, 8'h00);
    wr(4'h2, 8'hE4);
    cyc(2);
    rd(4'hD, 4'h2);
    check(d, 8'hE4);
    pulse(8'h05);
    rd(4'hD, 4'h9);
    check(d, 8'hFF);
    check(wide_irq, 1'b1);
    wr(4'h2, 8'hD4);
    pulse(8'h05);
    rd(4'hD, 4'h2);
    check(d, 8'hE4);
    check(wide_irq, 1'b0);
    wr(4'h0, 8'hC0);
    cyc(12);
    rd(4'hD, 4'h2);
    check(d, 8'hF4);
    wr(4'h2, 8'hB4);
    wr(4'h2, 8'hC4);
    pulse(8'h05);
    rd(4'hD, 4'h2);
    check(d, 8'hF4);
    wr(4'h0, 8'h20);
    wr(4'h2, 8'h30);
    wr(4'h1, 8'h00);
    $display("capture test done");
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #2;
    rst_b = 1'b1;
    t_logic;
    t_force;
    t_wide;
    t_narrow;
    t_demod;
    t_pingpong;
    t_capture;
    give_verdict;
  end
  // About nine times the expected length of the run
  initial begin
    #(25 * 20000);
    err_total++;
    give_verdict;
  end
endmodule // tb_dual_counter_transmit_demod
